/* File: rtl/ppm_pkg.sv */
// ppm_pkg: constants, types and mode decoding for the port-mode register block.
// assumes one 125 MHz clock and a synchronous active-low reset in every user.
package ppm_pkg;

  localparam int NUM_PORTS = 4;
  localparam int MODE_W = 2;
  localparam int REG_W = 8;

  // command codes selected by the host after the device address
  localparam logic [7:0] CMD_STRAP_ADDR = 8'h11;
  localparam logic [7:0] CMD_PORT_MODE = 8'h12;
  localparam logic [7:0] PORT_MODE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // device address layout: prefix, four straps, internal lowest bit
  localparam logic [1:0] ADDR_PREFIX = 2'h1;
  localparam logic [6:0] BROADCAST_ADDR = 7'h7f;
  localparam logic READBACK_PAD_HI = 1'h0;
  localparam logic [1:0] READBACK_PAD_LO = 2'h0;
  localparam int STRAP_W = 4;

  // mode field encodings
  localparam logic [1:0] MODE_CODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CODE_MANUAL = 2'h1;

  // serial byte bit counting
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;

  typedef enum logic [1:0] {PPM_OFF, PPM_MANUAL, PPM_SEMI} ppm_mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} ppm_bus_st_e;
  typedef enum logic [1:0] {BK_ADDR, BK_CMD, BK_DATA} ppm_byte_e;

  function automatic ppm_mode_e ppm_decode_mode(input logic [1:0] field);
    ppm_mode_e m;
    if (field == MODE_CODE_OFF) begin
      m = PPM_OFF;
    end else if (field == MODE_CODE_MANUAL) begin
      m = PPM_MANUAL;
    end else begin
      m = PPM_SEMI;
    end
    return m;
  endfunction : ppm_decode_mode

endpackage : ppm_pkg

/* File: rtl/ppm_port_ctl.sv */
// ppm_port_ctl: per-port mode handling, power state bits and their change events.
// assumes port power inputs come from logic on the same clock.
`timescale 1ns/1ns
module ppm_port_ctl (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] mode_field_i,
  input wire logic port_powered_i,
  input wire logic power_good_i,
  input wire logic detect_enable_bit_i,
  input wire logic class_enable_bit_i,
  input wire logic detect_valid_i,
  output logic off_clear_o,
  output logic detect_run_o,
  output logic class_run_o,
  output logic port_on_state_o,
  output logic power_good_state_o,
  output logic power_good_change_event_o,
  output logic power_enable_change_event_o
);
  import ppm_pkg::*;

  ppm_mode_e mode;
  logic is_off;
  logic is_manual;
  logic pe_ff;
  logic pg_ff;
  logic pgc_ff;
  logic pec_ff;
  logic nxt_pe;
  logic nxt_pg;

  assign mode = ppm_decode_mode(mode_field_i);
  assign is_off = (mode == PPM_OFF);
  assign is_manual = (mode == PPM_MANUAL);

  // level, not pulse: holds the port's events, results, enables and fault bit cleared
  assign off_clear_o = is_off;

  // off runs nothing; detection only while unpowered, so cycles repeat in semi-auto
  assign detect_run_o = ~is_off & detect_enable_bit_i & ~pe_ff;
  // semi-auto classifies only after a valid detection; no power-on request exists here
  assign class_run_o = ~is_off & class_enable_bit_i & ~pe_ff
                       & (is_manual | detect_valid_i);

  // off forces the power bits low; power good latches until the port turns off
  assign nxt_pe = ~is_off & port_powered_i;
  assign nxt_pg = nxt_pe & (pg_ff | power_good_i);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pe_ff <= 1'b0;
      pg_ff <= 1'b0;
      pgc_ff <= 1'b0;
      pec_ff <= 1'b0;
    end else begin
      pe_ff <= nxt_pe;
      pg_ff <= nxt_pg;
      pgc_ff <= nxt_pg ^ pg_ff;
      pec_ff <= nxt_pe ^ pe_ff;
    end
  end

  assign port_on_state_o = pe_ff;
  assign power_good_state_o = pg_ff;
  assign power_good_change_event_o = pgc_ff;
  assign power_enable_change_event_o = pec_ff;

endmodule : ppm_port_ctl

/* File: rtl/ppm_port_mode_regs.sv */
// ppm_port_mode_regs: two-wire serial slave holding the strap address readback
// and the per-port mode register, plus one port controller per port.
// assumes scl/sda and strap pins are asynchronous; port inputs share clock_i.
//
// What this block does
// - command 11h reads back the strap-derived address, one byte, read only.
// - readback bits 6..2 show the serial address from straps and internal bit.
// - the internal lowest address bit is fixed 0 or 1, shown in bit 2.
// - configuration A allows either value; configuration B always reads 0.
// - command 12h reads and writes the one-byte mode register, reset 0.
// - port 1 mode in bits 1..0, up to port 4 in bits 7..6.
// - mode 00 off, 01 manual, 10 and 11 semi-automatic.
// - off runs no detection or class; manual makes no automatic changes.
// - semi-auto detects and classifies itself but never powers on alone.
// - off clears class/detect events, fault flags, start fault, stored results.
// - off also clears class and detect enables and power-on fault bit.
// - off updates the port's power-on and power-good bits to match.
// - a power-on or power-good change sets the matching change events.
// - power-on state reads 1 while on and 0 while off.
// - semi-auto repeats detection and class while off and enabled; class needs valid detect.
`timescale 1ns/1ns
module ppm_port_mode_regs #(
  parameter bit CONFIG_B = 1'b0,
  parameter bit INTERNAL_LSB = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [ppm_pkg::STRAP_W-1:0] address_strap_pins_i,
  input wire logic [ppm_pkg::NUM_PORTS-1:0] port_powered_i,
  input wire logic [ppm_pkg::NUM_PORTS-1:0] power_good_i,
  input wire logic [ppm_pkg::NUM_PORTS-1:0] detect_enable_bit_i,
  input wire logic [ppm_pkg::NUM_PORTS-1:0] class_enable_bit_i,
  input wire logic [ppm_pkg::NUM_PORTS-1:0] detect_valid_i,
  output logic [ppm_pkg::NUM_PORTS-1:0] off_clear_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] detect_run_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] class_run_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] port_on_state_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] power_good_state_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] power_good_change_event_o,
  output logic [ppm_pkg::NUM_PORTS-1:0] power_enable_change_event_o,
  output logic [ppm_pkg::REG_W-1:0] port_mode_select_o
);
  import ppm_pkg::*;

  // pin synchronisers; the meta stage feeds only the sync stage
  logic scl_meta_ff;
  logic scl_sync_ff;
  logic scl_prev_ff;
  logic sda_meta_ff;
  logic sda_sync_ff;
  logic sda_prev_ff;
  logic [STRAP_W-1:0] strap_meta_ff;
  logic [STRAP_W-1:0] strap_sync_ff;

  // bus engine state
  ppm_bus_st_e state_ff;
  ppm_bus_st_e nxt_state;
  ppm_byte_e kind_ff;
  ppm_byte_e nxt_kind;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [REG_W-1:0] sh_ff;
  logic [REG_W-1:0] nxt_sh;
  logic rw_ff;
  logic nxt_rw;
  logic [REG_W-1:0] cmd_ff;
  logic [REG_W-1:0] nxt_cmd;
  logic [REG_W-1:0] mode_ff;
  logic [REG_W-1:0] nxt_mode;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic addr_lsb;
  logic [6:0] own_addr;
  logic [6:0] rx_addr;
  logic addr_hit;
  logic [REG_W-1:0] strap_readback;
  logic [REG_W-1:0] rd_data;
  logic byte_done;
  logic cmd_is_strap;
  logic cmd_is_mode;
  logic sda_oe_ff;
  logic nxt_sda_oe;

  // one serial bit into the low end of the shift register, msb first on the wire
  function automatic logic [REG_W-1:0] shift_in(input logic [REG_W-1:0] v, input logic b);
    return {v[REG_W-2:0], b};
  endfunction : shift_in

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  // straps are static in use but may still move at power-up, so they are synchronised too
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
    end else begin
      strap_meta_ff <= address_strap_pins_i;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  assign scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff & scl_prev_ff;
  // start and stop: sda moves while scl stays high
  assign bus_start = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign bus_stop = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  // configuration B pins the internal bit low whatever the parameter says
  assign addr_lsb = CONFIG_B ? 1'b0 : INTERNAL_LSB;
  assign own_addr = {ADDR_PREFIX, strap_sync_ff, addr_lsb};
  assign rx_addr = sh_ff[REG_W-1:1];
  // broadcast answers writes only: several devices driving read data would collide
  assign addr_hit = (rx_addr == own_addr)
                    | ((rx_addr == BROADCAST_ADDR) & ~sh_ff[0]);

  assign strap_readback = {READBACK_PAD_HI, strap_sync_ff, addr_lsb,
                           READBACK_PAD_LO};
  // decoded once and shared by the read mux and the write path
  assign cmd_is_strap = (cmd_ff == CMD_STRAP_ADDR);
  assign cmd_is_mode = (cmd_ff == CMD_PORT_MODE);
  assign rd_data = cmd_is_strap ? strap_readback :
                   cmd_is_mode ? mode_ff :
                   READ_UNMAPPED;

  assign byte_done = scl_fall & (cnt_ff == BIT_CNT_FULL);

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rw = rw_ff;
    nxt_cmd = cmd_ff;
    nxt_mode = mode_ff;
    if (bus_stop) begin
      nxt_state = ST_IDLE;
    end else if (bus_start) begin
      nxt_state = ST_RX;
      nxt_kind = BK_ADDR;
      nxt_cnt = BIT_CNT_ZERO;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_cnt = BIT_CNT_ZERO;
        end
        ST_RX: begin
          if (scl_rise) begin
            nxt_sh = shift_in(sh_ff, sda_sync_ff);
            nxt_cnt = 4'(cnt_ff + BIT_CNT_ONE);
          end else if (byte_done) begin
            nxt_cnt = BIT_CNT_ZERO;
            unique case (kind_ff)
              BK_ADDR: begin
                if (addr_hit) begin
                  nxt_state = ST_ACK;
                  nxt_rw = sh_ff[0];
                end else begin
                  nxt_state = ST_IDLE;
                end
              end
              BK_CMD: begin
                nxt_cmd = sh_ff;
                nxt_state = ST_ACK;
              end
              BK_DATA: begin
                // writes to the readback or unknown commands are acknowledged and dropped
                if (cmd_is_mode) begin
                  nxt_mode = sh_ff;
                end
                nxt_state = ST_ACK;
              end
              default: begin
                nxt_state = ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_state = ST_TX;
              nxt_sh = rd_data;
              nxt_cnt = BIT_CNT_ZERO;
            end else begin
              nxt_state = ST_RX;
              nxt_kind = (kind_ff == BK_ADDR) ? BK_CMD : BK_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == BIT_CNT_LAST) begin
              nxt_state = ST_TXACK;
            end else begin
              nxt_sh = shift_in(sh_ff, 1'b0);
              nxt_cnt = 4'(cnt_ff + BIT_CNT_ONE);
            end
          end
        end
        ST_TXACK: begin
          // host nack ends the read; ack repeats the same register
          if (scl_rise && sda_sync_ff) begin
            nxt_state = ST_IDLE;
          end else if (scl_fall) begin
            nxt_state = ST_TX;
            nxt_sh = rd_data;
            nxt_cnt = BIT_CNT_ZERO;
          end
        end
        // an upset into an unused state code returns to idle instead of hanging
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      kind_ff <= BK_ADDR;
      cnt_ff <= BIT_CNT_ZERO;
      sh_ff <= '0;
      rw_ff <= 1'b0;
      cmd_ff <= '0;
      sda_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rw_ff <= nxt_rw;
      cmd_ff <= nxt_cmd;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // kept apart from the bus engine: only a finished data byte to 12h moves it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_ff <= PORT_MODE_RESET;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // open drain: only ever pull low, during ack and for zero data bits; taken from the
  // next state so the registered enable keeps the same timing without glitches
  assign nxt_sda_oe = (nxt_state == ST_ACK) | ((nxt_state == ST_TX) & ~nxt_sh[REG_W-1]);
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_ff;
  assign port_mode_select_o = mode_ff;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    ppm_port_ctl u_port (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .mode_field_i(mode_ff[p*MODE_W +: MODE_W]),
      .port_powered_i(port_powered_i[p]),
      .power_good_i(power_good_i[p]),
      .detect_enable_bit_i(detect_enable_bit_i[p]),
      .class_enable_bit_i(class_enable_bit_i[p]),
      .detect_valid_i(detect_valid_i[p]),
      .off_clear_o(off_clear_o[p]),
      .detect_run_o(detect_run_o[p]),
      .class_run_o(class_run_o[p]),
      .port_on_state_o(port_on_state_o[p]),
      .power_good_state_o(power_good_state_o[p]),
      .power_good_change_event_o(power_good_change_event_o[p]),
      .power_enable_change_event_o(power_enable_change_event_o[p])
    );
  end

endmodule : ppm_port_mode_regs

/* File: test/ppm_host_model.sv */
// ppm_host_model: two-wire serial host, bit-banged on the system clock.
// assumes a pull-up on the data wire; the device gives only its pull-down enable.
`timescale 1ns/1ns
module ppm_host_model (
  input wire logic clock_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic pull = 1'b0;
  initial scl_o = 1'b1;
  // a released line shows the pull-up level, never a stale driven value
  assign sda_o = ~(pull | sda_oe_i);
  task automatic hw(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : hw
  // six clocks low and six high, data moved only mid-low
  task automatic bit_io(input logic b, output logic r);
    pull = ~b;
    hw(3);
    scl_o = 1'b1;
    hw(3);
    r = sda_o;
    hw(3);
    scl_o = 1'b0;
    hw(3);
  endtask : bit_io
  task automatic start();
    pull = 1'b0;
    hw(3);
    scl_o = 1'b1;
    hw(6);
    pull = 1'b1;
    hw(6);
    scl_o = 1'b0;
    hw(3);
  endtask : start
  task automatic stop();
    pull = 1'b1;
    hw(3);
    scl_o = 1'b1;
    hw(6);
    pull = 1'b0;
    hw(6);
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic na, output logic [7:0] r,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(na, a);
    ack = ~a;
  endtask : xfer
endmodule : ppm_host_model

/* File: test/ppm_port_mode_regs_properties.sv */
// checker of the port control outputs against the mode register.
// assumes it is bound to ppm_port_mode_regs and sees only its ports.
`timescale 1ns/1ns
module ppm_port_mode_regs_properties #(
  parameter bit CONFIG_B = 1'b0,
  parameter bit INTERNAL_LSB = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] port_powered_i,
  input wire logic [3:0] detect_enable_bit_i,
  input wire logic [3:0] class_enable_bit_i,
  input wire logic [3:0] detect_valid_i,
  input wire logic [3:0] off_clear_o,
  input wire logic [3:0] detect_run_o,
  input wire logic [3:0] class_run_o,
  input wire logic [3:0] port_on_state_o,
  input wire logic [3:0] power_good_state_o,
  input wire logic [3:0] power_good_change_event_o,
  input wire logic [3:0] power_enable_change_event_o,
  input wire logic [7:0] port_mode_select_o
);
  logic [3:0] off_w, man_w;
  for (genvar p = 0; p < 4; p++) begin : g_dec
    assign off_w[p] = port_mode_select_o[2*p +: 2] == 2'h0;
    assign man_w[p] = port_mode_select_o[2*p +: 2] == 2'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_mode_reset_zero: assert property ($rose(rst_n_i) |-> port_mode_select_o == 8'h00)
    else $error("mode register not zero after reset");
  chk_off_clear_map: assert property (off_clear_o == off_w)
    else $error("off clear does not follow mode");
  // only judged once power and mode settled, so either reading of on-state agrees
  chk_detect_gate: assert property ($stable(port_powered_i) && $stable(port_mode_select_o)
    |-> detect_run_o == (~off_w & detect_enable_bit_i & ~port_on_state_o))
    else $error("detect run gating wrong");
  chk_class_gate: assert property ($stable(port_powered_i) && $stable(port_mode_select_o)
    |-> class_run_o == (~off_w & class_enable_bit_i & ~port_on_state_o
    & (man_w | detect_valid_i)))
    else $error("class run gating wrong");
  chk_on_state_follow: assert property (port_on_state_o == $past(~off_w & port_powered_i))
    else $error("port on state wrong");
  chk_pe_change_event: assert property (power_enable_change_event_o
    == (port_on_state_o ^ $past(port_on_state_o)))
    else $error("power enable change event wrong");
  chk_pg_change_event: assert property (power_good_change_event_o
    == (power_good_state_o ^ $past(power_good_state_o)))
    else $error("power good change event wrong");
  chk_pg_off_clear: assert property ((|($past(off_w) & power_good_state_o)) == 1'b0)
    else $error("power good kept in off mode");
endmodule : ppm_port_mode_regs_properties

bind ppm_port_mode_regs ppm_port_mode_regs_properties #(.CONFIG_B(CONFIG_B),
  .INTERNAL_LSB(INTERNAL_LSB)) u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .port_powered_i(port_powered_i), .detect_enable_bit_i(detect_enable_bit_i),
  .class_enable_bit_i(class_enable_bit_i), .detect_valid_i(detect_valid_i),
  .off_clear_o(off_clear_o), .detect_run_o(detect_run_o), .class_run_o(class_run_o),
  .port_on_state_o(port_on_state_o), .power_good_state_o(power_good_state_o),
  .power_good_change_event_o(power_good_change_event_o),
  .power_enable_change_event_o(power_enable_change_event_o),
  .port_mode_select_o(port_mode_select_o));

/* File: test/test_ppm_port_mode_regs.sv */
// test_ppm_port_mode_regs: register access over the serial bus and port controls.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module test_ppm_port_mode_regs;
  import ppm_pkg::*;
  localparam bit LSB = 1'b1;
  logic clock_i = 1'b0, rst_n_i = 1'b0, scl, sda, sda_oe, sda_oe_b, ack;
  logic [3:0] straps = 4'h0, pw = 4'h0, pg = 4'h0, den = 4'h0, cen = 4'h0, dv = 4'h0;
  logic [3:0] off_c, drun, crun, pon, pgs, pgc, pec;
  logic [7:0] msel, rdat, m;
  logic [7:0] evt_seen = 8'h00;
  logic evt_clr = 1'b0;
  int miscompares = 0, comparisons = 0, cycles = 0;
  initial forever #4 clock_i = ~clock_i;
  ppm_host_model host (.clock_i(clock_i), .sda_oe_i(sda_oe | sda_oe_b), .scl_o(scl),
    .sda_o(sda));
  ppm_port_mode_regs #(.CONFIG_B(1'b0), .INTERNAL_LSB(LSB)) dut (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .address_strap_pins_i(straps), .port_powered_i(pw), .power_good_i(pg),
    .detect_enable_bit_i(den), .class_enable_bit_i(cen), .detect_valid_i(dv),
    .off_clear_o(off_c), .detect_run_o(drun), .class_run_o(crun), .port_on_state_o(pon),
    .power_good_state_o(pgs), .power_good_change_event_o(pgc), .power_enable_change_event_o(pec),
    .port_mode_select_o(msel));
  // configuration b shares the bus; its lowest address bit is always 0, so it never collides
  ppm_port_mode_regs #(.CONFIG_B(1'b1), .INTERNAL_LSB(1'b1)) dut_b (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_b),
    .address_strap_pins_i(straps), .port_powered_i(pw), .power_good_i(pg),
    .detect_enable_bit_i(den), .class_enable_bit_i(cen), .detect_valid_i(dv),
    .off_clear_o(), .detect_run_o(), .class_run_o(), .port_on_state_o(),
    .power_good_state_o(), .power_good_change_event_o(), .power_enable_change_event_o(),
    .port_mode_select_o());
  function automatic logic [6:0] dev();
    return {2'b01, straps, LSB};
  endfunction : dev
  function automatic logic [15:0] exp_ports(input logic [7:0] md);
    logic [3:0] off, man, on;
    for (int p = 0; p < 4; p++) begin
      off[p] = md[2*p +: 2] == 2'b00;
      man[p] = md[2*p +: 2] == 2'b01;
    end
    on = ~off & pw;
    return {off, ~off & den & ~on, ~off & cen & ~on & (man | dv), on};
  endfunction : exp_ports
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, r, k0);
    host.xfer(c, 1'b1, r, k1);
    host.xfer(d, 1'b1, r, k2);
    host.stop();
    ok = k0 & k1 & k2;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, r, k);
    host.xfer(c, 1'b1, r, k);
    host.start();
    host.xfer({a, 1'b1}, 1'b1, r, k);
    host.xfer(8'hff, 1'b1, d, k);
    host.stop();
  endtask : rd
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  always @(posedge clock_i) begin
    cycles++;
    // sticky copy of the one-cycle change pulses, so a pulse inside a bus task is not missed
    evt_seen <= evt_clr ? 8'h00 : (evt_seen | {pgc, pec});
    // well above the roughly 22k cycles the sequence needs
    if (cycles == 80000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    void'($urandom(26562));
    settle(12);
    rst_n_i = 1'b1;
    settle(4);
    rd(dev(), CMD_PORT_MODE, rdat);
    chk("mode_reset", 16'(PORT_MODE_RESET), 16'(rdat));
    chk("off_clear_reset", 16'h000f, 16'(off_c));
    for (int i = 0; i < 6; i++) begin
      straps = (i < 2) ? {4{i[0]}} : 4'($urandom);
      settle(5);
      wr({2'b10, straps, LSB}, CMD_PORT_MODE, 8'hff, ack);
      chk("foreign_addr_ack", 16'h0, 16'(ack));
      wr(dev(), CMD_STRAP_ADDR, 8'hff, ack);
      rd(dev(), CMD_STRAP_ADDR, rdat);
      chk("strap_readback", {8'h0, 1'b0, straps, LSB, 2'b00}, 16'(rdat));
      rd({2'b01, straps, 1'b0}, CMD_STRAP_ADDR, rdat);
      chk("strap_readback_b", {8'h0, 1'b0, straps, 1'b0, 2'b00}, 16'(rdat));
    end
    rd(dev(), CMD_PORT_MODE, rdat);
    chk("mode_after_ro_write", 16'(PORT_MODE_RESET), 16'(rdat));
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 8'he4 : (i == 1) ? 8'h1b : 8'($urandom);
      wr(i[0] ? BROADCAST_ADDR : dev(), CMD_PORT_MODE, m, ack);
      chk("mode_write_ack", 16'h1, 16'(ack));
      rd(dev(), CMD_PORT_MODE, rdat);
      chk("mode_readback", {m, m}, {rdat, msel});
      {pw, pg, den, cen, dv} = 20'($urandom);
      settle(3);
      chk("port_controls", exp_ports(m), {off_c, drun, crun, pon});
    end
    wr(dev(), CMD_PORT_MODE, 8'haa, ack);
    {pw, pg} = 8'h00;
    settle(3);
    pw = 4'hf;
    pg = 4'hf;
    settle(1);
    chk("power_events", 16'h00ff, {8'h0, pgc, pec});
    settle(3);
    chk("powered_semi", 16'hff00, {pon, pgs, off_c, 4'h0});
    evt_clr = 1'b1;
    settle(1);
    evt_clr = 1'b0;
    wr(dev(), CMD_PORT_MODE, 8'h00, ack);
    settle(2);
    chk("off_entry_events", 16'h00ff, {8'h0, evt_seen});
    chk("off_entry", 16'h00f0, {pon, pgs, off_c, 4'h0});
    summarize();
  end
endmodule : test_ppm_port_mode_regs
